// ### rtl/scss_pkg.sv
// Purpose: Shared constants for the system clock source selector.
// Assumes: pclk at 250 MHz; all source inputs sampled on pclk.
// Notes: Register offsets are byte addresses of 32-bit words.
package scss_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SRC_LOSS_NS = 2000;
  localparam int unsigned SRC_LOSS_CYC = SRC_LOSS_NS / CLK_PERIOD_NS;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_EVT = 8'h0c;
  localparam logic [7:0] ADDR_UART = 8'h10;

  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int unsigned CMD_SWAP_COMP = 0;
  localparam int unsigned CMD_SWAP_HS = 1;
  localparam int unsigned CMD_STANDBY = 2;
  localparam int unsigned CMD_ACTIVE = 3;
  localparam int unsigned EVT_SKEW = 0;
  localparam int unsigned EVT_COMP_FAIL = 1;
  localparam int unsigned EVT_HS_FAIL = 2;
  localparam int unsigned EVT_W = 3;
  localparam int unsigned UART_BITS = 9;
  localparam int unsigned UART_FRAME = UART_BITS + 2;

  // ****************************************
  // Source indices
  // ****************************************
  localparam int unsigned SRC_COMP_P = 0;
  localparam int unsigned SRC_COMP_S = 1;
  localparam int unsigned SRC_HS_P = 2;
  localparam int unsigned SRC_HS_S = 3;
  localparam int unsigned SRC_DATA = 4;
  localparam int unsigned NUM_SRC = 5;

  typedef enum logic [1:0] {MODE_EXT, MODE_LOCAL, MODE_DERIVE} scss_mode_e;

endpackage

// ### rtl/scss_uart_if.sv
// Purpose: Link between the selector core and its 9-bit transmitter.
// Assumes: One pclk domain.
// Notes: start is a one-cycle request, honoured only while busy is low.
`timescale 1ns/1ps
`default_nettype none
interface scss_uart_if;
  logic start;
  logic [8:0] data;
  logic busy;
  logic txd;
  modport ctl(output start, output data, input busy, input txd);
  modport phy(input start, input data, output busy, output txd);
endinterface
`default_nettype wire

// ### rtl/scss_uart_tx.sv
// Purpose: Nine-bit asynchronous transmitter for shelf identity characters.
// Assumes: DIV pclk cycles per bit.
// Notes: Frame is one start bit, nine data bits LSB first, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module scss_uart_tx
  import scss_pkg::*;
#(
  parameter int unsigned DIV = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Character request and line
  scss_uart_if.phy u
);

  typedef enum logic {U_IDLE, U_SEND} scss_ustate_e;

  if (DIV < 1 || DIV > 65535) begin : g_chk
    $error("DIV out of range");
  end

  scss_ustate_e state_q;
  logic [UART_FRAME-1:0] sh_q;
  logic [3:0] nbit_q;
  logic [15:0] baud_q;
  wire logic take = (state_q == U_IDLE) && u.start;
  wire logic tick = (state_q == U_SEND) && (baud_q == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= U_IDLE;
      sh_q <= '1;
      nbit_q <= 4'h0;
      baud_q <= 16'h0000;
    end else if (take) begin
      state_q <= U_SEND;
      sh_q <= {1'b1, u.data, 1'b0};
      nbit_q <= 4'(UART_FRAME);
      baud_q <= 16'(DIV - 1);
    end else if (tick) begin
      sh_q <= {1'b1, sh_q[UART_FRAME-1:1]};
      nbit_q <= nbit_q - 4'h1;
      baud_q <= 16'(DIV - 1);
      if (nbit_q == 4'h1) begin
        state_q <= U_IDLE;
      end
    end else if (state_q == U_SEND) begin
      baud_q <= baud_q - 16'h0001;
    end
  end

  assign u.txd = sh_q[0];
  assign u.busy = (state_q == U_SEND);

  a_uart_start_bit: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> !u.txd && u.busy) else $error("start bit not sent");

  a_uart_stop_bit: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(u.busy) |-> u.txd) else $error("line not idle after frame");

endmodule
`default_nettype wire

// ### rtl/scss_top.sv
// Purpose: System clock source selection, distribution and slot sync.
// Assumes: Clock sources and peer sync are synchronous to pclk.
// Notes: Registers are reached over APB with zero wait states.
// Notes on behaviour
// - Each of the composite and high-speed source types has a primary and a secondary input, each checked for activity.
// - When the source in use loses validity and the other is valid, selection moves over.
// - The processor can force a primary/secondary swap or pick the local oscillator.
// - The composite timing output follows the selected composite input.
// - The selected high-speed input passes through to the high-speed output.
// - The local oscillator drives only the composite output, never the high-speed one.
// - With the local oscillator and no high-speed input, the high-speed output stays low.
// - Derive mode makes both outputs from the incoming E1/T1 data stream.
// - The composite output carries the slot counter sync as a missing pulse.
// - Standby hardware aligns its slot counter to the peer sync and reports the skew.
// - The active or standby role is readable and shown on a pin.
// - The processor can force the card from active to standby.
// - A nine-bit transmitter sends shelf identity characters.
`timescale 1ns/1ps
`default_nettype none
module scss_top
  import scss_pkg::*;
#(
  parameter int unsigned LOCAL_DIV = 16,
  parameter int unsigned HS_DIV = 8,
  parameter int unsigned DER_COMP_DIV = 4,
  parameter int unsigned SLOT_LEN = 64,
  parameter int unsigned UART_DIV = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timing sources
  input wire logic comp_pri_in,
  input wire logic comp_sec_in,
  input wire logic hs_pri_in,
  input wire logic hs_sec_in,
  input wire logic e1t1_data_in,
  // Peer card
  input wire logic peer_sync_in,
  // Distributed outputs
  output logic composite_timing_clock_out,
  output logic hs_clock_out,
  output logic slot_sync_out,
  output logic active_out,
  output logic shelf_id_txd
);

  // The local, derived composite and slot counters are 16 bits wide and the high-speed divider counter 8 bits, which sets the upper limits.
  if (LOCAL_DIV < 2 || LOCAL_DIV % 2 != 0 || HS_DIV < 2 || HS_DIV > 256 ||
      DER_COMP_DIV < 2 || DER_COMP_DIV % 2 != 0 || SLOT_LEN < 2 ||
      SLOT_LEN > 65536 || LOCAL_DIV > 131072 ||
      DER_COMP_DIV > 131072) begin : g_chk
    $error("Divider or counter parameter out of range");
  end

  localparam int unsigned LW = $clog2(SRC_LOSS_CYC + 1);

  // ****************************************
  // APB decode
  // ****************************************
  // Read data is loaded in the setup cycle, so it stands through the access cycle.
  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pwrite;
  wire logic hit = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_STAT) ||
                   (paddr == ADDR_EVT) || (paddr == ADDR_UART);
  wire logic wr_ctrl = apb_wr && (paddr == ADDR_CTRL);
  wire logic wr_cmd = apb_wr && (paddr == ADDR_CMD);
  wire logic wr_evt = apb_wr && (paddr == ADDR_EVT);
  wire logic wr_uart = apb_wr && (paddr == ADDR_UART);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // Source activity monitors
  // ****************************************
  // A source counts as valid while it has changed within the loss window.
  wire logic [NUM_SRC-1:0] src = {e1t1_data_in, hs_sec_in, hs_pri_in, comp_sec_in, comp_pri_in};
  logic [NUM_SRC-1:0] src_prev_q;
  logic [LW-1:0] loss_q [NUM_SRC];
  logic [NUM_SRC-1:0] valid;
  wire logic [NUM_SRC-1:0] src_edge = src ^ src_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= '0;
      for (int i = 0; i < NUM_SRC; i++) loss_q[i] <= '0;
    end else begin
      src_prev_q <= src;
      for (int i = 0; i < NUM_SRC; i++) begin
        if (src_edge[i]) loss_q[i] <= LW'(SRC_LOSS_CYC);
        else if (loss_q[i] != '0) loss_q[i] <= loss_q[i] - LW'(1);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) valid[i] = (loss_q[i] != '0);
  end

  // ****************************************
  // Primary and secondary selection
  // ****************************************
  logic comp_sec_q;
  logic hs_sec_q;
  scss_mode_e mode_q;
  logic active_q;
  logic [EVT_W-1:0] evt_q;
  wire logic comp_valid_sel = comp_sec_q ? valid[SRC_COMP_S] : valid[SRC_COMP_P];
  wire logic comp_valid_alt = comp_sec_q ? valid[SRC_COMP_P] : valid[SRC_COMP_S];
  wire logic hs_valid_sel = hs_sec_q ? valid[SRC_HS_S] : valid[SRC_HS_P];
  wire logic hs_valid_alt = hs_sec_q ? valid[SRC_HS_P] : valid[SRC_HS_S];
  wire logic comp_fail = !comp_valid_sel && comp_valid_alt;
  wire logic hs_fail = !hs_valid_sel && hs_valid_alt;
  wire logic swap_comp = wr_cmd && pwdata[CMD_SWAP_COMP];
  wire logic swap_hs = wr_cmd && pwdata[CMD_SWAP_HS];
  // A forced swap in the same cycle as a failover toggles the selection only once.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sec_q <= 1'b0;
      hs_sec_q <= 1'b0;
    end else begin
      if (comp_fail || swap_comp) comp_sec_q <= !comp_sec_q;
      if (hs_fail || swap_hs) hs_sec_q <= !hs_sec_q;
    end
  end

  // ****************************************
  // Mode and role
  // ****************************************
  wire logic [1:0] mode_wr = pwdata[1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= scss_mode_e'(CTRL_RST);
      active_q <= 1'b0;
    end else begin
      if (wr_ctrl && mode_wr != 2'h3) mode_q <= scss_mode_e'(mode_wr);
      if (wr_cmd && pwdata[CMD_STANDBY]) active_q <= 1'b0;
      else if (wr_cmd && pwdata[CMD_ACTIVE]) active_q <= 1'b1;
    end
  end

  assign active_out = active_q;

  // ****************************************
  // Local oscillator and data-derived clocks
  // ****************************************
  logic [15:0] loc_cnt_q;
  logic loc_clk_q;
  logic [7:0] der_cnt_q;
  logic [15:0] der_cc_q;
  logic der_comp_q;
  wire logic der_hs = der_cnt_q < 8'(HS_DIV / 2);
  wire logic der_wrap = der_cnt_q == 8'(HS_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_cnt_q <= 16'h0000;
      loc_clk_q <= 1'b0;
      der_cnt_q <= 8'h00;
      der_cc_q <= 16'h0000;
      der_comp_q <= 1'b0;
    end else begin
      loc_cnt_q <= (loc_cnt_q == 16'(LOCAL_DIV / 2 - 1)) ? 16'h0000 : loc_cnt_q + 16'h0001;
      if (loc_cnt_q == 16'(LOCAL_DIV / 2 - 1)) loc_clk_q <= !loc_clk_q;
      if (src_edge[SRC_DATA] || der_wrap) der_cnt_q <= 8'h00;
      else der_cnt_q <= der_cnt_q + 8'h01;
      if (der_wrap) begin
        der_cc_q <= (der_cc_q == 16'(DER_COMP_DIV / 2 - 1)) ? 16'h0000 : der_cc_q + 16'h0001;
        if (der_cc_q == 16'(DER_COMP_DIV / 2 - 1)) der_comp_q <= !der_comp_q;
      end
    end
  end

  // ****************************************
  // Output source muxing
  // ****************************************
  wire logic comp_sel_in = comp_sec_q ? comp_sec_in : comp_pri_in;
  wire logic hs_sel_in = (hs_sec_q ? hs_sec_in : hs_pri_in) && hs_valid_sel;
  wire logic base_comp = (mode_q == MODE_LOCAL) ? loc_clk_q :
                         (mode_q == MODE_DERIVE) ? der_comp_q : comp_sel_in;
  wire logic base_hs = (mode_q == MODE_DERIVE) ? der_hs : hs_sel_in;

  // ****************************************
  // Slot counter sync and skew removal
  // ****************************************
  logic base_prev_q;
  logic [15:0] slot_q;
  wire logic base_rise = base_comp && !base_prev_q;
  wire logic slot_end = slot_q == 16'(SLOT_LEN - 1);
  wire logic skew = !active_q && peer_sync_in && (slot_q != 16'h0000);
  // The output is gated by the next count, so the pulse that opens slot zero is left out whole.
  wire logic [15:0] slot_d = skew ? 16'h0000 : !base_rise ? slot_q :
                             slot_end ? 16'h0000 : slot_q + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_prev_q <= 1'b0;
      slot_q <= 16'h0000;
      slot_sync_out <= 1'b0;
      composite_timing_clock_out <= 1'b0;
      hs_clock_out <= 1'b0;
    end else begin
      base_prev_q <= base_comp;
      slot_q <= slot_d;
      slot_sync_out <= base_rise && slot_end;
      composite_timing_clock_out <= base_comp && (slot_d != 16'h0000);
      hs_clock_out <= base_hs;
    end
  end

  // ****************************************
  // Sticky events
  // ****************************************
  // A flag set in the same cycle as its clear stays set.
  wire logic [EVT_W-1:0] evt_set = {hs_fail, comp_fail, skew};
  wire logic [EVT_W-1:0] evt_clr = wr_evt ? pwdata[EVT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_q <= '0;
    else evt_q <= evt_set | (evt_q & ~evt_clr);
  end

  // ****************************************
  // Shelf identity transmitter
  // ****************************************
  scss_uart_if uif();
  assign uif.start = wr_uart && !uif.busy;
  assign uif.data = pwdata[UART_BITS-1:0];
  assign shelf_id_txd = uif.txd;

  scss_uart_tx #(.DIV(UART_DIV)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .u(uif)
  );

  // ****************************************
  // Read data
  // ****************************************
  wire logic [31:0] stat_word = {22'h0, valid[SRC_DATA], uif.busy, active_q, hs_sec_q,
                                 comp_sec_q, valid[SRC_HS_S], valid[SRC_HS_P],
                                 valid[SRC_COMP_S], valid[SRC_COMP_P], 1'b0};
  wire logic [31:0] rd_mux = (paddr == ADDR_CTRL) ? {30'h0, mode_q} :
                             (paddr == ADDR_STAT) ? stat_word :
                             (paddr == ADDR_EVT) ? {29'h0, evt_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (apb_setup) prdata <= rd_mux;
  end

  // ****************************************
  // Checks
  // ****************************************
  a_src_valid_edge: assert property (@(posedge pclk) disable iff (!presetn)
    src_edge[SRC_COMP_S] |=> valid[SRC_COMP_S]) else $error("edge did not validate");

  a_comp_failover: assert property (@(posedge pclk) disable iff (!presetn)
    (comp_fail && !swap_comp) |=> comp_sec_q != $past(comp_sec_q) && evt_q[EVT_COMP_FAIL])
    else $error("no failover");

  a_force_swap: assert property (@(posedge pclk) disable iff (!presetn)
    (swap_hs && !hs_fail) |=> hs_sec_q != $past(hs_sec_q)) else $error("swap ignored");

  a_hs_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == MODE_EXT && hs_valid_sel) |=>
    hs_clock_out == ($past(hs_sec_q) ? $past(hs_sec_in) : $past(hs_pri_in)))
    else $error("high-speed not passed");

  a_local_no_hs: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == MODE_LOCAL && !hs_valid_sel) |=> !hs_clock_out) else $error("hs from oscillator");

  a_comp_blank: assert property (@(posedge pclk) disable iff (!presetn)
    (slot_q == 16'h0000 && !base_rise) |=> !composite_timing_clock_out)
    else $error("sync slot not blanked");

  a_sync_slot_open: assert property (@(posedge pclk) disable iff (!presetn)
    (base_rise && slot_end) |=> slot_sync_out && !composite_timing_clock_out)
    else $error("sync slot pulse not left out");

  a_skew_fix: assert property (@(posedge pclk) disable iff (!presetn)
    skew |=> slot_q == 16'h0000 && evt_q[EVT_SKEW]) else $error("skew not removed");

  a_standby_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cmd && pwdata[CMD_STANDBY]) |=> !active_out ##1 (active_out == $past(active_q)))
    else $error("standby not taken");

  a_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_q[EVT_HS_FAIL] && !(wr_evt && pwdata[EVT_HS_FAIL])) |=> evt_q[EVT_HS_FAIL])
    else $error("event flag lost");

endmodule
`default_nettype wire

// ### sim/scss_src_model.sv
// Purpose: Far-side timing sources and peer card sync for the clock selector.
// Assumes: Sources are synchronous to pclk.
// Notes: A disabled source holds its level, as a lost clock does.
`timescale 1ns/1ps
`default_nettype none
module scss_src_model (
  // Clock
  input wire logic pclk,
  // Control from the bench
  input wire logic [4:0] src_en,
  input wire logic sync_req,
  // Source lines
  output logic comp_pri,
  output logic comp_sec,
  output logic hs_pri,
  output logic hs_sec,
  output logic data_line,
  output logic peer_sync
);
  logic [7:0] cnt_q = 8'h00;
  logic [5:0] out_q = 6'h00;

  // ****************************************
  // Sources with distinct rates
  // ****************************************
  // Primary and secondary run at different rates so a wrong selection shows.
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 8'h01;
    if (src_en[0] && cnt_q[1:0] == 2'h3) out_q[0] <= ~out_q[0];
    if (src_en[1] && cnt_q[3:0] == 4'hf) out_q[1] <= ~out_q[1];
    if (src_en[2]) out_q[2] <= ~out_q[2];
    if (src_en[3] && cnt_q[0]) out_q[3] <= ~out_q[3];
    // The data stream changes only on 8-cycle bit boundaries and skips one boundary in four.
    if (src_en[4] && cnt_q[2:0] == 3'h7 && cnt_q[4:3] != 2'h3) out_q[4] <= ~out_q[4];
    out_q[5] <= sync_req;
  end

  assign comp_pri = out_q[0];
  assign comp_sec = out_q[1];
  assign hs_pri = out_q[2];
  assign hs_sec = out_q[3];
  assign data_line = out_q[4];
  assign peer_sync = out_q[5];
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Purpose: Self-checking bench for the system clock source selector.
// Assumes: Short slot frame and fast transmitter parameters.
// Notes: Register cases run from a table; source handling is hand-written.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scss_pkg::*;
  localparam int SLOTS = 8;
  localparam int UDIV = 2;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic err;
  } scss_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] src_en = 5'h00;
  logic sync_req = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, c_p, c_s, h_p, h_s, dat, peer;
  wire logic comp_out, hs_clock_out, slot_sync_out, active_out, txd;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int r;
  logic [31:0] rd;
  logic er, prv;
  logic [9:0] ch;
  scss_row_s rows [10];

  always #2 pclk = ~pclk;

  scss_top #(.SLOT_LEN(SLOTS), .UART_DIV(UDIV)) u_scss_top (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_pri_in(c_p),
    .comp_sec_in(c_s), .hs_pri_in(h_p), .hs_sec_in(h_s), .e1t1_data_in(dat),
    .peer_sync_in(peer), .composite_timing_clock_out(comp_out), .hs_clock_out(hs_clock_out),
    .slot_sync_out(slot_sync_out), .active_out(active_out), .shelf_id_txd(txd));

  scss_src_model u_scss_src_model (.pclk(pclk), .src_en(src_en), .sync_req(sync_req),
    .comp_pri(c_p), .comp_sec(c_s), .hs_pri(h_p), .hs_sec(h_s), .data_line(dat),
    .peer_sync(peer));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask

  task automatic rises(input logic hs, input int n);
    r = 0;
    prv = 1'b1;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if ((hs ? hs_clock_out : comp_out) === 1'b1 && prv === 1'b0) r++;
      prv = hs ? hs_clock_out : comp_out;
    end
  endtask

  task automatic hs_pass(input logic sec);
    logic p;
    repeat (16) begin
      @(posedge pclk);
      p = sec ? h_s : h_p;
      #1;
      chk("hs_clock_out", {31'h0, hs_clock_out}, {31'h0, p});
    end
  endtask

  task automatic wait_sync();
    do begin
      @(posedge pclk);
      #1;
    end while (slot_sync_out !== 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows = '{'{1, ADDR_CTRL, 1, 0, 0}, '{0, ADDR_CTRL, 0, 1, 0}, '{1, ADDR_CTRL, 3, 0, 0},
      '{0, ADDR_CTRL, 0, 1, 0}, '{1, ADDR_CTRL, 2, 0, 0}, '{0, ADDR_CTRL, 0, 2, 0},
      '{1, ADDR_CTRL, 0, 0, 0}, '{0, ADDR_CMD, 0, 0, 0}, '{0, 8'h14, 0, 0, 1},
      '{1, 8'h14, 5, 0, 1}};
    repeat (12) @(posedge pclk);
    chk("txd_idle", {31'h0, txd}, 32'h1);
    chk("active_rst", {31'h0, active_out}, 32'h0);
    presetn <= 1'b1;
    rdchk("stat_rst", ADDR_STAT, 32'hffffffff, 32'h0);
    rdchk("evt_rst", ADDR_EVT, 32'hffffffff, 32'h0);
    for (int i = 0; i < 10; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("reg_rd", rd, rows[i].rd);
      chk("slverr", {31'h0, er}, {31'h0, rows[i].err});
    end
    src_en <= 5'h1f;
    repeat (20) @(posedge pclk);
    rdchk("stat_valid", ADDR_STAT, 32'h27e, 32'h21e);
    hs_pass(1'b0);
    apb(1'b1, ADDR_CMD, 32'h2);
    rdchk("hs_swap", ADDR_STAT, 32'h60, 32'h40);
    hs_pass(1'b1);
    apb(1'b1, ADDR_CMD, 32'h2);
    // One pulse in every slot frame is left out to carry the sync.
    wait_sync();
    rises(1'b0, SLOTS * 8);
    chk("frame_rises", r, SLOTS - 1);
    src_en <= 5'h1a;
    repeat (SRC_LOSS_CYC + 20) @(posedge pclk);
    rdchk("failover", ADDR_STAT, 32'h7e, 32'h74);
    rdchk("evt_fail", ADDR_EVT, 32'h7, 32'h6);
    apb(1'b1, ADDR_EVT, 32'h6);
    rdchk("evt_clr", ADDR_EVT, 32'h7, 32'h0);
    apb(1'b1, ADDR_CMD, 32'h8);
    repeat (3) @(posedge pclk);
    chk("go_active", {31'h0, active_out}, 32'h1);
    rdchk("stat_active", ADDR_STAT, 32'h80, 32'h80);
    apb(1'b1, ADDR_CMD, 32'hc);
    repeat (3) @(posedge pclk);
    chk("go_standby", {31'h0, active_out}, 32'h0);
    wait_sync();
    repeat (48) @(posedge pclk);
    sync_req <= 1'b1;
    @(posedge pclk);
    sync_req <= 1'b0;
    repeat (5) @(posedge pclk);
    rdchk("skew", ADDR_EVT, 32'h1, 32'h1);
    apb(1'b1, ADDR_EVT, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    src_en <= 5'h03;
    repeat (SRC_LOSS_CYC + 20) @(posedge pclk);
    rises(1'b1, 100);
    chk("local_hs", r, 0);
    rises(1'b0, 100);
    chk("local_comp", {31'h0, r != 0}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h2);
    src_en <= 5'h10;
    repeat (40) @(posedge pclk);
    rises(1'b1, 100);
    chk("derive_hs", {31'h0, r != 0}, 32'h1);
    rises(1'b0, 200);
    chk("derive_comp", {31'h0, r != 0}, 32'h1);
    rdchk("data_valid", ADDR_STAT, 32'h200, 32'h200);
    apb(1'b1, ADDR_UART, 32'h1a5);
    do begin
      @(posedge pclk);
      #1;
    end while (txd !== 1'b0);
    for (int b = 0; b < 10; b++) begin
      repeat (UDIV) @(posedge pclk);
      #1;
      ch[b] = txd;
    end
    chk("uart_char", {22'h0, ch}, {22'h0, 1'b1, 9'h1a5});
    repeat (30) @(posedge pclk);
    rdchk("uart_idle", ADDR_STAT, 32'h100, 32'h0);
    // A reset in mid-run puts mode, role and source selection back to their idle values.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("active_midrst", {31'h0, active_out}, 32'h0);
    presetn <= 1'b1;
    rdchk("mode_midrst", ADDR_CTRL, 32'h3, 32'h0);
    rdchk("sel_midrst", ADDR_STAT, 32'h60, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
